// file: rtl/rx_fifo_pkg.sv
/*
  Constants, register map and carrier types of the receive queue block.
  Assumes one 100 MHz system clock and an active-low asynchronous reset.
*/
// ---------------------------------------------------------------
// Overview of operation
// - skip bit drops head packet, then self-clears
// - skip moves data pointers only, receiver running
// - flush resets both queues' pointers, self-clears
// - optional checksum dword appended after payload
// - status bits 31,14,9:8,0 read zero
// - bit 30 marks address filter failure
// - bits 29:16 hold frame byte count
// - bit 15 ORs bits 11,7,6,1
// - bit 13 broadcast, bit 10 multicast
// - bit 12 length field mismatch
// - bit 11 runt; runts need pass-bad
// - bit 7 over 1518 bytes, not truncated
// - bit 6 late collision seen
// - bit 5 type field over 1500
// - bit 4 receive watchdog expired
// - bit 3 receive error during frame
// - bit 2 dribbling bits, not with collision
// - bit 1 crc error or receive error
// - enable bit halts, halt event, restart
// ---------------------------------------------------------------
`default_nettype none

package rx_fifo_pkg;

  // ---------------------------------------------------------------
  // register map, byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_RX_DATA = 8'h00;
  localparam logic [7:0] ADDR_RX_STATUS = 8'h04;
  localparam logic [7:0] ADDR_QUEUE_INFO = 8'h08;
  localparam logic [7:0] ADDR_RX_CONFIG = 8'h0C;
  localparam logic [7:0] ADDR_RX_DATAPATH_CONTROL = 8'h10;
  localparam logic [7:0] ADDR_CHECKSUM_OFFLOAD_CONTROL = 8'h14;
  localparam logic [7:0] ADDR_MAC_CONTROL = 8'h18;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_FLUSH = 15;
  localparam int BIT_SKIP = 31;
  localparam int BIT_CSUM_EN = 0;
  localparam int BIT_RX_ENABLE = 2;
  localparam int BIT_PASS_BAD = 16;
  localparam int BIT_HALTED = 31;
  localparam int STAT_FILTER_FAIL = 30;
  localparam int STAT_LEN_LSB = 16;
  localparam int STAT_ERR_SUM = 15;
  localparam int STAT_BCAST = 13;
  localparam int STAT_LEN_MISMATCH = 12;
  localparam int STAT_RUNT = 11;
  localparam int STAT_MCAST = 10;
  localparam int STAT_TOO_LONG = 7;
  localparam int STAT_LATE_COLL = 6;
  localparam int STAT_FRAME_TYPE = 5;
  localparam int STAT_WATCHDOG = 4;
  localparam int STAT_RX_ERR = 3;
  localparam int STAT_DRIBBLE = 2;
  localparam int STAT_CRC_ERR = 1;

  // ---------------------------------------------------------------
  // reset values and frame limits
  // ---------------------------------------------------------------
  localparam logic [31:0] RST_MAC_CONTROL = 32'h0000_0000;
  localparam logic [31:0] RST_CSUM_CONTROL = 32'h0000_0000;
  localparam logic [13:0] RUNT_BYTES = 14'd64;
  localparam logic [13:0] MAX_FRAME_BYTES = 14'd1518;
  localparam logic [13:0] WATCHDOG_BYTES = 14'd2048;
  localparam logic [13:0] MIN_TYPE_BYTES = 14'd14;
  localparam logic [15:0] MAX_LEN_FIELD = 16'd1500;
  localparam logic [15:0] HDR_CRC_BYTES = 16'd18;
  localparam logic [2:0] DRIBBLE_MII = 3'd4;
  localparam logic [2:0] DRIBBLE_10M = 3'd3;

  // ---------------------------------------------------------------
  // queue geometry
  // ---------------------------------------------------------------
  localparam int DATA_AW = 9;
  localparam int STAT_AW = 4;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic last;
    logic [31:0] data;
  } mil_word_s;

  typedef struct packed {
    logic [13:0] byte_len;
    logic [15:0] len_type;
    logic filter_fail;
    logic broadcast;
    logic multicast;
    logic late_coll;
    logic rx_er_seen;
    logic crc_bad;
    logic [2:0] dribble_bits;
    logic speed_10;
    logic [31:0] checksum;
  } frame_info_s;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_FRAME = 3'b010,
    RX_CSUM = 3'b100
  } rx_state_e;

  typedef enum logic [1:0] {
    SK_IDLE = 2'b01,
    SK_RUN = 2'b10
  } skip_state_e;

endpackage

`default_nettype wire

// file: rtl/rx_fifo_discard_and_status.sv
/*
  Receive data and status queues: packet skip, flush, status word forming.
  Assumes one dword per cycle, frame info on the last, an idle cycle after it.
*/
`default_nettype none

module rx_fifo_discard_and_status
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire rx_fifo_pkg::mil_word_s mil_word_i,
  input wire rx_fifo_pkg::frame_info_s frame_info_i,
  output logic receiver_halted_event_o
);
  import rx_fifo_pkg::*;

  localparam int DATA_DEPTH = 1 << DATA_AW;
  localparam int STAT_DEPTH = 1 << STAT_AW;
  localparam logic [DATA_AW:0] DATA_FULL = (DATA_AW + 1)'(DATA_DEPTH);
  localparam logic [STAT_AW:0] STAT_FULL = (STAT_AW + 1)'(STAT_DEPTH);

  // ---------------------------------------------------------------
  // status word forming
  // ---------------------------------------------------------------
  function automatic logic [31:0] build_status(input frame_info_s fi);
    logic [31:0] s;
    logic runt;
    logic expect_ok;
    logic [15:0] expect_len;
    s = 32'h0000_0000;
    runt = fi.byte_len < RUNT_BYTES;
    expect_len = fi.len_type + HDR_CRC_BYTES;
    if (expect_len < {2'b00, RUNT_BYTES})
    begin
      expect_ok = ({2'b00, fi.byte_len} == {2'b00, RUNT_BYTES});
    end
    else
    begin
      expect_ok = ({2'b00, fi.byte_len} == expect_len);
    end
    s[STAT_FILTER_FAIL] = fi.filter_fail;
    s[STAT_LEN_LSB +: 14] = fi.byte_len;
    s[STAT_BCAST] = fi.broadcast;
    s[STAT_MCAST] = fi.multicast;
    s[STAT_LEN_MISMATCH] = (fi.len_type <= MAX_LEN_FIELD) && !runt && !expect_ok;
    s[STAT_RUNT] = runt;
    s[STAT_TOO_LONG] = fi.byte_len > MAX_FRAME_BYTES;
    s[STAT_LATE_COLL] = fi.late_coll;
    s[STAT_FRAME_TYPE] = (fi.len_type > MAX_LEN_FIELD) && (fi.byte_len >= MIN_TYPE_BYTES);
    s[STAT_WATCHDOG] = fi.byte_len > WATCHDOG_BYTES;
    s[STAT_RX_ERR] = fi.rx_er_seen;
    if (!fi.late_coll)
    begin
      s[STAT_DRIBBLE] = fi.speed_10 ? (fi.dribble_bits >= DRIBBLE_10M)
                                    : (fi.dribble_bits == DRIBBLE_MII);
    end
    s[STAT_CRC_ERR] = fi.crc_bad | fi.rx_er_seen;
    s[STAT_ERR_SUM] = s[STAT_RUNT] | s[STAT_TOO_LONG] | s[STAT_LATE_COLL]
                    | s[STAT_CRC_ERR];
    return s;
  endfunction

  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] ref_a);
    return a == ref_a;
  endfunction

  // ---------------------------------------------------------------
  // storage and state
  // ---------------------------------------------------------------
  logic [32:0] data_mem [DATA_DEPTH];
  logic [31:0] stat_mem [STAT_DEPTH];
  logic [DATA_AW:0] d_rd_ff;
  logic [DATA_AW:0] d_wr_ff;
  logic [DATA_AW:0] d_commit_ff;
  logic [STAT_AW:0] s_rd_ff;
  logic [STAT_AW:0] s_wr_ff;
  logic flush_ff;
  logic skip_ff;
  logic [31:0] csum_ctrl_ff;
  logic [31:0] mac_ctrl_ff;
  logic [31:0] rdata_ff;
  logic halted_ff;
  logic halt_evt_ff;
  logic accept_ff;
  logic overflow_ff;
  logic [31:0] pend_status_ff;
  logic [31:0] pend_csum_ff;
  logic pend_ok_ff;
  rx_state_e rx_state_ff;
  skip_state_e sk_state_ff;

  logic rx_enable;
  logic csum_en;
  logic pass_bad;
  logic [DATA_AW:0] d_used;
  logic [DATA_AW:0] d_space;
  logic [STAT_AW:0] s_used;
  logic d_full;
  logic s_full;
  logic d_avail;
  logic s_avail;
  logic pop_data;
  logic pop_stat;
  logic wr_word;
  logic [32:0] wr_payload;
  logic commit;
  logic discard;
  logic [31:0] new_status;
  logic skip_step;
  logic skip_done;
  logic [DATA_AW:0] nxt_d_rd;

  assign rx_enable = mac_ctrl_ff[BIT_RX_ENABLE];
  assign pass_bad = mac_ctrl_ff[BIT_PASS_BAD];
  assign csum_en = csum_ctrl_ff[BIT_CSUM_EN];
  assign d_used = d_commit_ff - d_rd_ff;
  assign d_space = d_wr_ff - d_rd_ff;
  assign s_used = s_wr_ff - s_rd_ff;
  assign d_full = d_space == DATA_FULL;
  assign s_full = s_used == STAT_FULL;
  assign d_avail = d_used != '0;
  assign s_avail = s_used != '0;
  assign new_status = build_status(frame_info_i);
  assign rdata_o = rdata_ff;
  assign receiver_halted_event_o = halt_evt_ff;

  // no pops while a skip is pending
  assign pop_data = rd_i && is_addr(addr_i, ADDR_RX_DATA) && d_avail && !skip_ff;
  assign pop_stat = rd_i && is_addr(addr_i, ADDR_RX_STATUS) && s_avail && !skip_ff;

  // ---------------------------------------------------------------
  // receive write side
  // ---------------------------------------------------------------
  always_comb
  begin
    wr_word = 1'b0;
    wr_payload = {1'b0, mil_word_i.data};
    commit = 1'b0;
    discard = 1'b0;
    case (rx_state_ff)
      RX_IDLE, RX_FRAME:
      begin
        if (mil_word_i.valid && (accept_ff || (rx_state_ff == RX_IDLE && rx_enable)))
        begin
          wr_word = !d_full;
          // payload stays untagged when a checksum dword follows
          wr_payload = {mil_word_i.last && !csum_en, mil_word_i.data};
        end
        if (mil_word_i.valid && mil_word_i.last && !csum_en)
        begin
          commit = frame_ok_now();
          discard = !commit;
        end
      end
      RX_CSUM:
      begin
        wr_word = !d_full && pend_ok_ff;
        wr_payload = {1'b1, pend_csum_ff};
        commit = pend_ok_ff && !d_full;
        discard = !commit;
      end
      default:
      begin
        wr_word = 1'b0;
      end
    endcase
  end

  function automatic logic frame_ok_now();
    logic take;
    take = accept_ff || (rx_state_ff == RX_IDLE && rx_enable);
    return take && !overflow_ff && !d_full && !s_full
           && (!new_status[STAT_RUNT] || pass_bad);
  endfunction

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rx_state_ff <= RX_IDLE;
      accept_ff <= 1'b0;
      overflow_ff <= 1'b0;
      pend_ok_ff <= 1'b0;
      pend_status_ff <= 32'h0000_0000;
      pend_csum_ff <= 32'h0000_0000;
    end
    else if (flush_ff)
    begin
      rx_state_ff <= RX_IDLE;
      accept_ff <= 1'b0;
      overflow_ff <= 1'b0;
      pend_ok_ff <= 1'b0;
    end
    else
    begin
      case (rx_state_ff)
        RX_IDLE, RX_FRAME:
        begin
          if (mil_word_i.valid)
          begin
            if (mil_word_i.last)
            begin
              rx_state_ff <= csum_en ? RX_CSUM : RX_IDLE;
              pend_ok_ff <= frame_ok_now();
              pend_status_ff <= new_status;
              pend_csum_ff <= frame_info_i.checksum;
              accept_ff <= 1'b0;
              overflow_ff <= 1'b0;
            end
            else
            begin
              rx_state_ff <= RX_FRAME;
              if (rx_state_ff == RX_IDLE)
              begin
                accept_ff <= rx_enable;
              end
              if (d_full)
              begin
                overflow_ff <= 1'b1;
              end
            end
          end
        end
        RX_CSUM:
        begin
          rx_state_ff <= RX_IDLE;
          pend_ok_ff <= 1'b0;
        end
        default:
        begin
          rx_state_ff <= RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (wr_word)
    begin
      data_mem[d_wr_ff[DATA_AW-1:0]] <= wr_payload;
    end
    if (commit)
    begin
      stat_mem[s_wr_ff[STAT_AW-1:0]] <= (rx_state_ff == RX_CSUM) ? pend_status_ff
                                                                 : new_status;
    end
  end

  // ---------------------------------------------------------------
  // pointers
  // ---------------------------------------------------------------
  assign skip_step = (sk_state_ff == SK_RUN) && d_avail;
  assign skip_done = (sk_state_ff == SK_RUN)
                  && (!d_avail || data_mem[d_rd_ff[DATA_AW-1:0]][32]);
  assign nxt_d_rd = d_rd_ff + (DATA_AW + 1)'(pop_data || skip_step);

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      d_rd_ff <= '0;
      d_wr_ff <= '0;
      d_commit_ff <= '0;
      s_rd_ff <= '0;
      s_wr_ff <= '0;
    end
    else if (flush_ff)
    begin
      d_rd_ff <= '0;
      d_wr_ff <= '0;
      d_commit_ff <= '0;
      s_rd_ff <= '0;
      s_wr_ff <= '0;
    end
    else
    begin
      d_rd_ff <= nxt_d_rd;
      if (commit)
      begin
        d_wr_ff <= d_wr_ff + (DATA_AW + 1)'(wr_word);
        d_commit_ff <= d_wr_ff + (DATA_AW + 1)'(wr_word);
        s_wr_ff <= s_wr_ff + 1'b1;
      end
      else if (discard)
      begin
        d_wr_ff <= d_commit_ff; // drop partial frame
      end
      else if (wr_word)
      begin
        d_wr_ff <= d_wr_ff + 1'b1;
      end
      if (pop_stat) // skip never moves the status pointer
      begin
        s_rd_ff <= s_rd_ff + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // skip engine, runs while the receiver keeps writing
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sk_state_ff <= SK_IDLE;
    end
    else
    begin
      case (sk_state_ff)
        SK_IDLE:
        begin
          if (skip_ff && !flush_ff)
          begin
            sk_state_ff <= SK_RUN;
          end
        end
        SK_RUN:
        begin
          if (skip_done || flush_ff)
          begin
            sk_state_ff <= SK_IDLE;
          end
        end
        default:
        begin
          sk_state_ff <= SK_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      skip_ff <= 1'b0;
    end
    else if (sk_state_ff == SK_RUN && (skip_done || flush_ff))
    begin
      skip_ff <= 1'b0;
    end
    else if (wr_i && is_addr(addr_i, ADDR_RX_DATAPATH_CONTROL) && wdata_i[BIT_SKIP])
    begin
      skip_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      flush_ff <= 1'b0;
    end
    else if (flush_ff)
    begin
      flush_ff <= 1'b0;
    end
    else if (wr_i && is_addr(addr_i, ADDR_RX_CONFIG) && wdata_i[BIT_FLUSH])
    begin
      flush_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      csum_ctrl_ff <= RST_CSUM_CONTROL;
      mac_ctrl_ff <= RST_MAC_CONTROL;
    end
    else if (wr_i)
    begin
      if (is_addr(addr_i, ADDR_CHECKSUM_OFFLOAD_CONTROL))
      begin
        csum_ctrl_ff <= wdata_i;
      end
      if (is_addr(addr_i, ADDR_MAC_CONTROL))
      begin
        mac_ctrl_ff <= wdata_i;
      end
    end
  end

  // halted once disabled and no frame in flight; event pulses on entry
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      halted_ff <= 1'b1;
      halt_evt_ff <= 1'b0;
    end
    else
    begin
      halted_ff <= !rx_enable && rx_state_ff == RX_IDLE && !mil_word_i.valid;
      halt_evt_ff <= !halted_ff && !rx_enable && rx_state_ff == RX_IDLE
                  && !mil_word_i.valid;
    end
  end

  // ---------------------------------------------------------------
  // read data, one cycle after the strobe
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_ff <= 32'h0000_0000;
    end
    else if (rd_i)
    begin
      case (addr_i)
        ADDR_RX_DATA:
        begin
          rdata_ff <= pop_data ? data_mem[d_rd_ff[DATA_AW-1:0]][31:0] : 32'h0000_0000;
        end
        ADDR_RX_STATUS:
        begin
          rdata_ff <= pop_stat ? stat_mem[s_rd_ff[STAT_AW-1:0]] : 32'h0000_0000;
        end
        ADDR_QUEUE_INFO:
        begin
          rdata_ff <= {halted_ff, 2'b00, 5'(s_used), 8'h00, 6'h00, d_used};
        end
        ADDR_RX_CONFIG:
        begin
          rdata_ff <= 32'(flush_ff) << BIT_FLUSH;
        end
        ADDR_RX_DATAPATH_CONTROL:
        begin
          rdata_ff <= 32'(skip_ff) << BIT_SKIP;
        end
        ADDR_CHECKSUM_OFFLOAD_CONTROL:
        begin
          rdata_ff <= csum_ctrl_ff;
        end
        ADDR_MAC_CONTROL:
        begin
          rdata_ff <= mac_ctrl_ff;
        end
        default:
        begin
          rdata_ff <= 32'h0000_0000;
        end
      endcase
    end
    else
    begin
      rdata_ff <= 32'h0000_0000;
    end
  end

endmodule // rx_fifo_discard_and_status

`default_nettype wire

// file: test/rx_fifo_discard_and_status_properties.sv
/*
  Port-level checks: status fields, idle read data, halt event.
  Assumes the design package; bound at the foot of this file.
*/
`default_nettype none

module rx_fifo_discard_and_status_properties
  import rx_fifo_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire rx_fifo_pkg::mil_word_s mil_word_i,
  input wire rx_fifo_pkg::frame_info_s frame_info_i,
  input wire logic receiver_halted_event_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic en_ff;
  logic in_frame_ff;
  logic st_ff;
  wire logic [13:0] len = rdata_o[29:16];

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  // ---------------------------------------------------------------
  // helper state
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      en_ff <= 1'b0;
      in_frame_ff <= 1'b0;
      st_ff <= 1'b0;
    end
    else
    begin
      st_ff <= rd_i && addr_i == ADDR_RX_STATUS;
      if (wr_i && addr_i == ADDR_MAC_CONTROL)
        en_ff <= wdata_i[BIT_RX_ENABLE];
      if (mil_word_i.valid)
        in_frame_ff <= !mil_word_i.last;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_rdata_idle_zero: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data not zero outside read answer");
  a_unmapped_read_zero: assert property (rd_i && addr_i > ADDR_MAC_CONTROL |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_reserved_bits_zero: assert property (rd_i && addr_i == ADDR_RX_STATUS |=>
    rdata_o[31] == 1'b0 && rdata_o[14] == 1'b0 && rdata_o[9:8] == 2'h0 && rdata_o[0] == 1'b0)
    else $error("reserved status bit set");
  a_err_summary_or: assert property (st_ff |->
    rdata_o[15] == (rdata_o[11] | rdata_o[7] | rdata_o[6] | rdata_o[1]))
    else $error("error summary wrong");
  a_runt_flag_len: assert property (st_ff && rdata_o != 32'h0 |-> rdata_o[11] == (len < RUNT_BYTES))
    else $error("runt flag wrong");
  a_too_long_len: assert property (st_ff |-> rdata_o[7] == (len > MAX_FRAME_BYTES))
    else $error("too long flag wrong");
  a_watchdog_flag_len: assert property (st_ff |-> rdata_o[4] == (len > WATCHDOG_BYTES))
    else $error("watchdog flag wrong");
  a_frame_type_runt: assert property (st_ff && len < MIN_TYPE_BYTES |-> rdata_o[5] == 1'b0)
    else $error("frame type set on short runt");
  a_dribble_no_coll: assert property (st_ff && rdata_o[6] |-> rdata_o[2] == 1'b0)
    else $error("dribble set with late collision");
  a_halt_event_after: assert property (wr_i && addr_i == ADDR_MAC_CONTROL &&
    !wdata_i[BIT_RX_ENABLE] && en_ff && !in_frame_ff && !mil_word_i.valid
    |-> ##[1:3] receiver_halted_event_o)
    else $error("no halt event after receiver disable");
  a_halt_event_pulse: assert property (receiver_halted_event_o |=> !receiver_halted_event_o)
    else $error("halt event longer than one cycle");

  c_status_error: cover property (st_ff && rdata_o[15]);
  c_halt_event: cover property (receiver_halted_event_o);
  c_skip_write: cover property (wr_i && addr_i == ADDR_RX_DATAPATH_CONTROL && wdata_i[BIT_SKIP]);
  c_flush_write: cover property (wr_i && addr_i == ADDR_RX_CONFIG && wdata_i[BIT_FLUSH]);

endmodule // rx_fifo_discard_and_status_properties

bind rx_fifo_discard_and_status rx_fifo_discard_and_status_properties
  rx_fifo_discard_and_status_properties_i (.clk_sys_i, .rst_n_i, .addr_i, .wdata_i, .wr_i,
  .rd_i, .rdata_o, .mil_word_i, .frame_info_i, .receiver_halted_event_o);

`default_nettype wire

// file: test/mil_source_model.sv
/*
  Interface layer model: one frame, a dword per cycle.
  Assumes the bench calls send; an idle cycle follows each last dword.
*/
`default_nettype none

module mil_source_model
  import rx_fifo_pkg::*;
(
  input wire logic clk_sys_i,
  output var rx_fifo_pkg::mil_word_s mil_word_o,
  output var rx_fifo_pkg::frame_info_s frame_info_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    mil_word_o = '0;
    frame_info_o = '0;
  end

  // info is valid only beside the last dword; idle lines show inverted junk
  task automatic send(input int n, input logic [31:0] base, input frame_info_s info);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_sys_i);
      mil_word_o <= '{valid: 1'b1, last: (i == n - 1), data: base + 32'(i)};
      frame_info_o <= (i == n - 1) ? info : ~info;
    end
    @(posedge clk_sys_i);
    mil_word_o <= '{valid: 1'b0, last: 1'b0, data: ~(base + 32'(n - 1))};
    frame_info_o <= ~info;
  endtask

endmodule // mil_source_model

`default_nettype wire

// file: test/rx_fifo_discard_and_status_tb_top.sv
/*
  Self-checking bench: status, flush, checksum, skip.
  Assumes the package, the frame source model and the bound checker.
*/
`default_nettype none

module rx_fifo_discard_and_status_tb_top
  import rx_fifo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys_i;
  logic rst_n_i;
  logic [7:0] addr_i;
  logic [31:0] wdata_i;
  logic wr_i;
  logic rd_i;
  logic [31:0] rdata_o;
  logic halt_ev;
  mil_word_s mil_word;
  frame_info_s frame_info;
  int n_fail = 0;
  int n_tests = 0;
  int cycles = 0;

  rx_fifo_discard_and_status rx_fifo_discard_and_status_i (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .mil_word_i(mil_word), .frame_info_i(frame_info),
    .receiver_halted_event_o(halt_ev));

  mil_source_model mil_source_model_i (.clk_sys_i(clk_sys_i), .mil_word_o(mil_word),
    .frame_info_o(frame_info));

  // ---------------------------------------------------------------
  // common tasks
  // ---------------------------------------------------------------
  task automatic end_sim();
    if (n_fail == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %0t %s: saw %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp, what);
  endtask

  function automatic frame_info_s fi(input logic [13:0] bl, input logic [15:0] lt,
    input logic [9:0] fl, input logic [31:0] cs = 32'h0);
    return frame_info_s'({bl, lt, fl, cs});
  endfunction

  function automatic logic [31:0] exp_status(input frame_info_s f);
    logic [31:0] s;
    logic [15:0] want;
    s = 32'h0;
    want = f.len_type + HDR_CRC_BYTES;
    if (want < 16'h0040)
      want = 16'h0040;
    s[30] = f.filter_fail;
    s[29:16] = f.byte_len;
    s[13] = f.broadcast;
    s[10] = f.multicast;
    s[11] = f.byte_len < RUNT_BYTES;
    s[12] = f.len_type <= MAX_LEN_FIELD && !s[11] && {2'h0, f.byte_len} != want;
    s[7] = f.byte_len > MAX_FRAME_BYTES;
    s[6] = f.late_coll;
    s[5] = f.len_type > MAX_LEN_FIELD && f.byte_len >= MIN_TYPE_BYTES;
    s[4] = f.byte_len > WATCHDOG_BYTES;
    s[3] = f.rx_er_seen;
    s[2] = !f.late_coll && (f.speed_10 ? f.dribble_bits >= DRIBBLE_10M
      : f.dribble_bits == DRIBBLE_MII);
    s[1] = f.crc_bad | f.rx_er_seen;
    s[15] = s[11] | s[7] | s[6] | s[1];
    return s;
  endfunction

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rc(ADDR_MAC_CONTROL, RST_MAC_CONTROL, "mac reset");
    rc(ADDR_CHECKSUM_OFFLOAD_CONTROL, RST_CSUM_CONTROL, "csum reset");
    rc(ADDR_QUEUE_INFO, 32'h8000_0000, "info reset");
    wr(8'h40, 32'hFFFF_FFFF);
    rc(8'h40, 32'h0, "unmapped");
    rc(ADDR_RX_STATUS, 32'h0, "empty status");
  endtask

  task automatic t_status();
    frame_info_s t [6];
    t = '{fi(14'h040, 16'h0800, 10'h000), fi(14'h5EF, 16'h002E, 10'h300),
      fi(14'h03C, 16'h0800, 10'h0C8), fi(14'h801, 16'h0800, 10'h027),
      fi(14'h00C, 16'h0800, 10'h016), fi(14'h064, 16'h0052, 10'h008)};
    wr(ADDR_MAC_CONTROL, 32'h0000_0004);
    mil_source_model_i.send(4, 32'h1000_0000, fi(14'h03C, 16'h0800, 10'h000));
    rc(ADDR_QUEUE_INFO, 32'h0, "runt dropped");
    wr(ADDR_MAC_CONTROL, 32'h0001_0004);
    foreach (t[i])
    begin
      mil_source_model_i.send(4, 32'h2000_0000 + 32'(i), t[i]);
      rc(ADDR_RX_STATUS, exp_status(t[i]), "status word");
    end
    rc(ADDR_QUEUE_INFO, 32'h0000_0018, "data count");
  endtask

  task automatic t_flush();
    logic ev;
    wr(ADDR_MAC_CONTROL, 32'h0001_0000);
    ev = 1'b0;
    repeat (4)
    begin
      @(posedge clk_sys_i);
      #1;
      ev |= halt_ev;
    end
    chk({31'h0, ev}, 32'h1, "halt event");
    rc(ADDR_QUEUE_INFO, 32'h8000_0018, "halted");
    wr(ADDR_RX_CONFIG, 32'h0000_8000);
    rc(ADDR_RX_CONFIG, 32'h0, "flush clears");
    rc(ADDR_QUEUE_INFO, 32'h8000_0000, "queues empty");
    rc(ADDR_RX_DATA, 32'h0, "data empty");
    wr(ADDR_MAC_CONTROL, 32'h0001_0004);
  endtask

  task automatic t_csum();
    wr(ADDR_CHECKSUM_OFFLOAD_CONTROL, 32'h0000_0001);
    mil_source_model_i.send(3, 32'h3000_0000, fi(14'h040, 16'h0800, 10'h000, 32'hC5C5_0001));
    rc(ADDR_QUEUE_INFO, 32'h0100_0004, "csum count");
    rc(ADDR_RX_STATUS, 32'h0040_0020, "csum status");
    for (int i = 0; i < 3; i++)
      rc(ADDR_RX_DATA, 32'h3000_0000 + 32'(i), "payload");
    rc(ADDR_RX_DATA, 32'hC5C5_0001, "csum dword");
    wr(ADDR_CHECKSUM_OFFLOAD_CONTROL, 32'h0);
  endtask

  task automatic t_skip();
    logic [31:0] d;
    int n;
    mil_source_model_i.send(6, 32'h4000_0000, fi(14'h040, 16'h0800, 10'h000));
    mil_source_model_i.send(4, 32'h5000_0000, fi(14'h040, 16'h0800, 10'h000));
    fork
      wr(ADDR_RX_DATAPATH_CONTROL, 32'h8000_0000);
      mil_source_model_i.send(4, 32'h6000_0000, fi(14'h040, 16'h0800, 10'h000));
    join
    n = 0;
    do
    begin
      rd(ADDR_RX_DATAPATH_CONTROL, d);
      n++;
    end while (d[31] === 1'b1 && n < 20);
    chk(d, 32'h0, "skip clears");
    repeat (4) @(posedge clk_sys_i);
    rc(ADDR_QUEUE_INFO, 32'h0300_0008, "status kept");
    for (int i = 0; i < 4; i++)
      rc(ADDR_RX_DATA, 32'h5000_0000 + 32'(i), "next packet");
    rc(ADDR_RX_DATA, 32'h6000_0000, "live packet");
  endtask

  // ---------------------------------------------------------------
  // clock, timeout, main sequence
  // ---------------------------------------------------------------
  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      n_fail++;
      end_sim();
    end
  end

  initial
  begin
    rst_n_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    repeat (16) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_status();
    t_flush();
    t_csum();
    t_skip();
    end_sim();
  end

endmodule // rx_fifo_discard_and_status_tb_top

`default_nettype wire
